//--- coulomb_counter_consts.vh
// register map, field positions, reset values and timing constants of the coulomb counter core
`ifndef COULOMB_COUNTER_CONSTS_VH
`define COULOMB_COUNTER_CONSTS_VH
`define ADDR_STATUS_CONTROL 8'h01
`define ADDR_SPECIAL_FEATURE 8'h08
`define ADDR_CURRENT_HIGH 8'h0e
`define ADDR_CURRENT_LOW 8'h0f
`define ADDR_CHARGE_HIGH 8'h10
`define ADDR_CHARGE_LOW 8'h11
`define BIT_SLEEP_ENABLE 6
`define BIT_OPCODE_SELECT 4
`define BIT_GPIO 6
`define RST_SLEEP_ENABLE 1'b0
`define RST_OPCODE_SELECT 1'b0
`define RST_GPIO 1'b1
`define OPCODE_READ_ID_0 8'h33
`define OPCODE_READ_ID_1 8'h39
`define OFFSET_EVERY 1024
`define CLK_HZ 10000000
`define CONV_HI_MS 3515
`define CONV_LO_MS 875
`define SLEEP_LOW_MS 2000
`define SAMPLE_HZ 18600
`define CONV_HI_CYC (`CLK_HZ / 1000 * `CONV_HI_MS)
`define CONV_LO_CYC (`CLK_HZ / 1000 * `CONV_LO_MS)
`define SLEEP_LOW_CYC (`CLK_HZ / 1000 * `SLEEP_LOW_MS)
`define SAMPLE_CYC (`CLK_HZ / `SAMPLE_HZ)
`endif

//--- coulomb_counter_measure_regs.v
// measurement, accumulation and byte-addressed register core of the coulomb counter
//
// Functional notes
// - high-resolution variant: 15 bits plus sign, 1.5625uV LSB, 3.515s period.
// - low-resolution variant: 13 bits plus sign, 6.25uV LSB, 0.875s period.
// - every 1024th conversion measures own input offset instead of sense input.
// - offset correction applies to the 1023 following current measurements.
// - during offset conversion the current register keeps the previous measurement.
// - previous measurement is accumulated in place of the lost sample.
// - each conversion period end except one that coincides with an accumulator write and the two after it adds the signed current into the accumulator.
// - visible accumulator LSB 6.25uVh, signed range plus or minus 204.8mVh.
// - sub-LSB accumulation bits are internal and not host accessible.
// - host write of the accumulator clears hidden fractional bits.
// - host accumulator write forces an offset measurement and new correction.
// - after an accumulator write, measurement resumes from the third conversion.
// - reading the upper byte snapshots both bytes until read command ends.
// - decode status 01, feature 08, current 0e/0f, accumulator 10/11.
// - sleep-enable bit 6 lets a 2s low data line cause sleep; resets 0.
// - opcode-select bit 4 picks read-identity opcode 33h or 39h; resets 0.
// - sleep stops measurement and accumulation; register access still works.
// - converter samples at 18.6kHz, current register updates per conversion.
`include "coulomb_counter_consts.vh"
module coulomb_counter_measure_regs #(
   parameter HIGH_RES = 1,
   parameter CONV_HI_CYCLES = `CONV_HI_CYC,
   parameter CONV_LO_CYCLES = `CONV_LO_CYC,
   parameter SLEEP_CYCLES = `SLEEP_LOW_CYC,
   parameter SAMPLE_CYCLES = `SAMPLE_CYC,
   parameter FRAC_BITS = 8
) (
   input wire clk_i,
   input wire sys_rst_i,
   input wire [7:0] reg_addr_i,
   input wire reg_wr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_rd_i,
   input wire read_cmd_end_i,
   input wire data_line_i,
   input wire signed [15:0] adc_result_i,
   input wire general_io_pin_i,
   output reg [7:0] reg_rdata_o,
   output reg sample_strobe_o,
   output reg offset_conv_o,
   output reg sleep_o,
   output reg [7:0] read_identity_opcode_o,
   output reg general_io_pin_oe_o,
   output reg general_io_pin_o
);

   // decodes one byte address into its register slot; 7 means reserved
   function [2:0] addr_slot;
      input [7:0] a;
      begin
         case (a)
            `ADDR_STATUS_CONTROL: addr_slot = 3'h0;
            `ADDR_SPECIAL_FEATURE: addr_slot = 3'h1;
            `ADDR_CURRENT_HIGH: addr_slot = 3'h2;
            `ADDR_CURRENT_LOW: addr_slot = 3'h3;
            `ADDR_CHARGE_HIGH: addr_slot = 3'h4;
            `ADDR_CHARGE_LOW: addr_slot = 3'h5;
            default: addr_slot = 3'h7;
         endcase
      end
   endfunction

   localparam [31:0] CONV_CYCLES = HIGH_RES ? CONV_HI_CYCLES : CONV_LO_CYCLES;
   localparam [9:0] LAST_CONV = 10'h3ff;

   reg sleep_on_line_low_enable_ff;
   reg read_identity_opcode_select_ff;
   reg gpio_ctl_ff;
   reg [31:0] conv_cnt_ff;
   reg [31:0] sample_cnt_ff;
   reg [31:0] low_cnt_ff;
   reg [9:0] conv_idx_ff;
   reg [1:0] skip_ff;
   reg force_offset_ff;
   reg signed [15:0] offset_ff;
   reg signed [15:0] current_ff;
   reg signed [15:0] charge_accumulator_ff;
   reg [FRAC_BITS-1:0] frac_ff;
   reg [15:0] snap_ff;
   reg snap_valid_ff;
   reg sleep_ff;

   wire [2:0] wr_slot = addr_slot(reg_addr_i);
   wire conv_end = (conv_cnt_ff == CONV_CYCLES - 32'h1) && !sleep_ff;
   wire is_offset = (conv_idx_ff == LAST_CONV) || force_offset_ff;
   wire acr_wr = reg_wr_i && (wr_slot == 3'h4 || wr_slot == 3'h5);

   // corrected sample masked to the variant's resolution
   wire signed [16:0] corr_wide = {adc_result_i[15], adc_result_i} - {offset_ff[15], offset_ff};
   wire signed [15:0] corr_sat = (corr_wide > 17'sh07fff) ? 16'sh7fff :
                                 (corr_wide < -17'sh08000) ? 16'sh8000 : corr_wide[15:0];
   wire signed [15:0] corr_val = HIGH_RES ? corr_sat : {corr_sat[15:2], 2'b00};

   // charge step: current times period in sub-LSB units of the accumulator
   wire signed [15:0] add_val = is_offset ? current_ff : corr_val;
   // both operands are full width, so a negative step is sign extended, not zero padded
   wire signed [FRAC_BITS+16:0] acc_step = {charge_accumulator_ff[15], charge_accumulator_ff, frac_ff}
      + {{(FRAC_BITS-4){add_val[15]}}, add_val, 5'h00};

   // status and feature control registers
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sleep_on_line_low_enable_ff <= `RST_SLEEP_ENABLE;
         read_identity_opcode_select_ff <= `RST_OPCODE_SELECT;
         gpio_ctl_ff <= `RST_GPIO;
      end else begin
         if (reg_wr_i && wr_slot == 3'h0) begin
            sleep_on_line_low_enable_ff <= reg_wdata_i[`BIT_SLEEP_ENABLE];
            read_identity_opcode_select_ff <= reg_wdata_i[`BIT_OPCODE_SELECT];
         end
         // pin control returns released on sleep entry or a long low line, whatever the enable bit
         if (sleep_ff || (!data_line_i && low_cnt_ff >= SLEEP_CYCLES - 32'h1))
            gpio_ctl_ff <= `RST_GPIO;
         else if (reg_wr_i && wr_slot == 3'h1)
            gpio_ctl_ff <= reg_wdata_i[`BIT_GPIO];
      end
   end

   // data-line low timer and sleep state
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         low_cnt_ff <= 32'h0;
         sleep_ff <= 1'b0;
      end else begin
         if (data_line_i) begin
            low_cnt_ff <= 32'h0;
            sleep_ff <= 1'b0; // a high line wakes the device
         end else if (low_cnt_ff < SLEEP_CYCLES - 32'h1) begin
            low_cnt_ff <= low_cnt_ff + 32'h1;
         end else if (sleep_on_line_low_enable_ff) begin
            sleep_ff <= 1'b1;
         end
      end
   end

   // conversion timebase and sample clock, frozen while asleep
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         conv_cnt_ff <= 32'h0;
         sample_cnt_ff <= 32'h0;
      end else if (!sleep_ff) begin
         conv_cnt_ff <= conv_end ? 32'h0 : conv_cnt_ff + 32'h1;
         sample_cnt_ff <= (sample_cnt_ff == SAMPLE_CYCLES - 32'h1) ? 32'h0 : sample_cnt_ff + 32'h1;
      end
   end

   // offset scheduling, current register and accumulator
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         conv_idx_ff <= 10'h0;
         force_offset_ff <= 1'b0;
         skip_ff <= 2'h0;
         offset_ff <= 16'sh0;
         current_ff <= 16'sh0;
         charge_accumulator_ff <= 16'sh0;
         frac_ff <= {FRAC_BITS{1'b0}};
      end else if (acr_wr) begin
         frac_ff <= {FRAC_BITS{1'b0}};
         force_offset_ff <= 1'b1;
         skip_ff <= 2'h2;
         if (wr_slot == 3'h4)
            charge_accumulator_ff[15:8] <= reg_wdata_i;
         else
            charge_accumulator_ff[7:0] <= reg_wdata_i;
      end else if (conv_end) begin
         conv_idx_ff <= is_offset ? 10'h0 : conv_idx_ff + 10'h1;
         if (is_offset) begin
            offset_ff <= adc_result_i;
            force_offset_ff <= 1'b0;
         end else if (skip_ff == 2'h0) begin
            current_ff <= corr_val;
         end
         if (skip_ff != 2'h0)
            skip_ff <= skip_ff - 2'h1;
         else begin
            charge_accumulator_ff <= acc_step[FRAC_BITS+15:FRAC_BITS];
            frac_ff <= acc_step[FRAC_BITS-1:0];
         end
      end
   end

   // two-byte snapshot on upper byte reads
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         snap_ff <= 16'h0;
         snap_valid_ff <= 1'b0;
      end else if (reg_rd_i && (wr_slot == 3'h2 || wr_slot == 3'h4)) begin
         snap_ff <= (wr_slot == 3'h2) ? current_ff : charge_accumulator_ff;
         snap_valid_ff <= 1'b1;
      end else if (read_cmd_end_i) begin
         snap_valid_ff <= 1'b0;
      end
   end

   // registered read data and outputs
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 8'h00;
         sample_strobe_o <= 1'b0;
         offset_conv_o <= 1'b0;
         sleep_o <= 1'b0;
         read_identity_opcode_o <= `OPCODE_READ_ID_0;
         general_io_pin_oe_o <= 1'b0;
         general_io_pin_o <= 1'b0;
      end else begin
         if (reg_rd_i) begin
            case (wr_slot)
               3'h0: reg_rdata_o <= {1'b0, sleep_on_line_low_enable_ff, 1'b0,
                                     read_identity_opcode_select_ff, 4'h0};
               3'h1: reg_rdata_o <= {1'b0, general_io_pin_i, 6'h00};
               3'h2: reg_rdata_o <= current_ff[15:8];
               3'h3: reg_rdata_o <= snap_valid_ff ? snap_ff[7:0] : current_ff[7:0];
               3'h4: reg_rdata_o <= charge_accumulator_ff[15:8];
               3'h5: reg_rdata_o <= snap_valid_ff ? snap_ff[7:0] : charge_accumulator_ff[7:0];
               default: reg_rdata_o <= 8'h00;
            endcase
         end
         sample_strobe_o <= !sleep_ff && (sample_cnt_ff == SAMPLE_CYCLES - 32'h1);
         offset_conv_o <= is_offset && !sleep_ff;
         sleep_o <= sleep_ff;
         read_identity_opcode_o <= read_identity_opcode_select_ff ? `OPCODE_READ_ID_1 : `OPCODE_READ_ID_0;
         general_io_pin_oe_o <= !gpio_ctl_ff; // open drain pulls low only
         general_io_pin_o <= 1'b0;
      end
   end

endmodule

//--- cc_measure_chk.sv
// port-level assertions for the coulomb counter register core
module cc_measure_chk #(
   parameter CONV_HI_CYCLES = 40,
   parameter SLEEP_CYCLES = 20
) (
   input wire clk_i,
   input wire sys_rst_i,
   input wire [7:0] reg_addr_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire data_line_i,
   input wire [7:0] reg_rdata_o,
   input wire sample_strobe_o,
   input wire offset_conv_o,
   input wire sleep_o,
   input wire [7:0] read_identity_opcode_o,
   input wire general_io_pin_oe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int OFS_WAIT = CONV_HI_CYCLES + 2;
   int low_cnt_ff;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // low time of the data line, saturated so it never wraps
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) low_cnt_ff <= 0;
      else if (data_line_i) low_cnt_ff <= 0;
      else if (low_cnt_ff < 100000) low_cnt_ff <= low_cnt_ff + 1;
   end
   // read data, strobe and opcode relations
   a_rdata_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   a_strobe_pulse: assert property (sample_strobe_o |=> !sample_strobe_o)
      else $error("sample strobe longer than one cycle");
   a_strobe_quiet: assert property (sleep_o && $past(sleep_o) |-> !sample_strobe_o)
      else $error("sampling while asleep");
   a_opcode_legal: assert property (read_identity_opcode_o == 8'h33 || read_identity_opcode_o == 8'h39)
      else $error("identity opcode out of range");
   // sleep entry needs a long low line, wake is prompt
   a_sleep_needs_low: assert property ($rose(sleep_o) |-> !data_line_i && low_cnt_ff >= SLEEP_CYCLES - 1)
      else $error("sleep entered without long low line");
   a_wake_on_high: assert property (sleep_o && data_line_i |-> ##[1:3] !sleep_o)
      else $error("no wake on high line");
   a_pin_release: assert property ($rose(sleep_o) |-> ##[0:2] !general_io_pin_oe_o)
      else $error("pin still driven in sleep");
   // accumulator write forces one offset conversion
   a_ofs_after_wr: assert property (reg_wr_i && !sleep_o && (reg_addr_i == 8'h10 || reg_addr_i == 8'h11)
      |-> ##[1:OFS_WAIT] offset_conv_o)
      else $error("no offset conversion after write");
   a_ofs_one_conv: assert property ($rose(offset_conv_o) |-> ##[1:OFS_WAIT] !offset_conv_o)
      else $error("offset conversion too long");
endmodule

//--- cc_host_model.sv
// host master model: byte register access and data line level
module cc_host_model (
   input wire clk_i,
   input wire [7:0] rdata_i,
   output logic [7:0] addr_o = 8'h00,
   output logic [7:0] wdata_o = 8'h00,
   output logic wr_o = 1'b0,
   output logic rd_o = 1'b0,
   output logic cmd_end_o = 1'b0,
   output logic line_o = 1'b1
);
   timeunit 1ns;
   timeprecision 1ns;
   // single byte write, strobe high one cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
   endtask
   // single byte read, data taken mid-cycle to avoid the edge race
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      @(negedge clk_i);
      d = rdata_i;
   endtask
   task automatic rd_pair(input logic [7:0] a, output logic [15:0] d);
      rd(a, d[15:8]);
      rd(a + 8'h01, d[7:0]);
      @(posedge clk_i);
      cmd_end_o <= 1'b1;
      @(posedge clk_i);
      cmd_end_o <= 1'b0;
   endtask
endmodule

//--- coulomb_counter_measure_regs_tb_top.sv
// self-checking bench of the coulomb counter register core
`include "coulomb_counter_consts.vh"
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, v); end end
module coulomb_counter_measure_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam CONV = 40;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic signed [15:0] adc = 16'sh0000;
   wire [7:0] addr, wdata, rdata, opcode;
   wire wr, rd, cmd_end, line, strobe, ofs, sleep, oe, pin_o;
   wire pin_lvl = oe ? 1'b0 : 1'b1; // pulled-up pin
   int num_errors = 0;
   int checked = 0;
   logic [15:0] v, w;
   always #50 clk_i = ~clk_i;
   cc_host_model u_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
      .rd_o(rd), .cmd_end_o(cmd_end), .line_o(line));
   coulomb_counter_measure_regs #(.CONV_HI_CYCLES(CONV), .CONV_LO_CYCLES(CONV), .SLEEP_CYCLES(20),
      .SAMPLE_CYCLES(4)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_wdata_i(wdata), .reg_rd_i(rd), .read_cmd_end_i(cmd_end), .data_line_i(line), .adc_result_i(adc),
      .general_io_pin_i(pin_lvl), .reg_rdata_o(rdata), .sample_strobe_o(strobe), .offset_conv_o(ofs),
      .sleep_o(sleep), .read_identity_opcode_o(opcode), .general_io_pin_oe_o(oe), .general_io_pin_o(pin_o));
   // prints counts and verdict, then stops
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // bounded wait on offset (0) or sleep (1) level
   task automatic wait_on(input int sel, input logic lvl);
      int n;
      n = 0;
      while ((sel ? sleep : ofs) !== lvl && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      if (n == 200) begin
         num_errors++;
         complete_run();
      end
   endtask
   // reset values, reserved place, opcode select
   task automatic t_regs();
      u_host.rd(`ADDR_STATUS_CONTROL, v[7:0]);
      `CHK("status", 8'h00, v[7:0])
      u_host.rd(`ADDR_SPECIAL_FEATURE, v[7:0]);
      `CHK("feature", 8'h40, v[7:0])
      u_host.wr(8'h05, 8'hff);
      u_host.rd(8'h05, v[7:0]);
      `CHK("reserved", 8'h00, v[7:0])
      u_host.wr(`ADDR_STATUS_CONTROL, 8'h10);
      u_host.rd(`ADDR_STATUS_CONTROL, v[7:0]);
      `CHK("opcode 1", `OPCODE_READ_ID_1, opcode)
      u_host.wr(`ADDR_STATUS_CONTROL, 8'hff);
      u_host.rd(`ADDR_STATUS_CONTROL, v[7:0]);
      `CHK("status bits", 8'h50, v[7:0])
      u_host.wr(`ADDR_STATUS_CONTROL, 8'h00);
      u_host.rd(`ADDR_STATUS_CONTROL, v[7:0]);
      `CHK("opcode 0", `OPCODE_READ_ID_0, opcode)
   endtask
   // offset taken at zero input, then steady current of 64 adds 8 per period
   task automatic t_measure();
      u_host.wr(`ADDR_CHARGE_HIGH, 8'h00);
      u_host.wr(`ADDR_CHARGE_LOW, 8'h00);
      wait_on(0, 1'b1);
      wait_on(0, 1'b0);
      @(posedge clk_i);
      adc <= 16'sh0040;
      repeat (3 * CONV) @(posedge clk_i);
      u_host.rd_pair(`ADDR_CURRENT_HIGH, v);
      `CHK("current", 16'h0040, v)
      u_host.rd_pair(`ADDR_CHARGE_HIGH, v);
      repeat (4 * CONV - 6) @(posedge clk_i);
      u_host.rd_pair(`ADDR_CHARGE_HIGH, w);
      `CHK("charge step", 16'h0020, w - v)
   endtask
   // accumulator write: current held through offset, written byte kept
   task automatic t_offset_hold();
      u_host.wr(`ADDR_CHARGE_HIGH, 8'h12);
      wait_on(0, 1'b1);
      u_host.rd_pair(`ADDR_CURRENT_HIGH, v);
      `CHK("held current", 16'h0040, v)
      u_host.rd(`ADDR_CHARGE_HIGH, v[7:0]);
      `CHK("charge high", 8'h12, v[7:0])
   endtask
   // sleep only with enable set; registers still reachable
   task automatic t_sleep();
      u_host.line_o <= 1'b0;
      repeat (40) @(posedge clk_i);
      `CHK("no sleep", 1'b0, sleep)
      u_host.line_o <= 1'b1;
      u_host.wr(`ADDR_STATUS_CONTROL, 8'h40);
      u_host.wr(`ADDR_SPECIAL_FEATURE, 8'h00);
      @(posedge clk_i);
      @(negedge clk_i);
      `CHK("pin driven", 1'b1, oe)
      u_host.line_o <= 1'b0;
      wait_on(1, 1'b1);
      @(negedge clk_i);
      `CHK("strobe asleep", 1'b0, strobe)
      `CHK("pin level", 1'b0, pin_o)
      u_host.rd(`ADDR_STATUS_CONTROL, v[7:0]);
      `CHK("sleep access", 8'h40, v[7:0])
      u_host.line_o <= 1'b1;
      wait_on(1, 1'b0);
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_regs();
      t_measure();
      t_offset_hold();
      t_sleep();
      complete_run();
   end
endmodule
bind coulomb_counter_measure_regs cc_measure_chk #(.CONV_HI_CYCLES(CONV_HI_CYCLES), .SLEEP_CYCLES(SLEEP_CYCLES))
   u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .data_line_i(data_line_i), .reg_rdata_o(reg_rdata_o), .sample_strobe_o(sample_strobe_o),
   .offset_conv_o(offset_conv_o), .sleep_o(sleep_o), .read_identity_opcode_o(read_identity_opcode_o),
   .general_io_pin_oe_o(general_io_pin_oe_o));
